/* design/rebp_cmp.sv */
// Break address comparator on the observed target bus
`include "rebp_defs.svh"
module rebp_cmp (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clk_en,
  // Comparator link
  rebp_cmp_if.cmp cif
);
  import rebp_pkg::*;

  logic hit_r;
  logic match;

  // ----------------------------------------------------------------
  // Compare
  // ----------------------------------------------------------------
  // Fetches are word or upper byte, so bit zero is left out
  assign match = cif.bus_valid && cif.bus_fetch && cif.armed &&
    cif.brk_en && (cif.bus_addr[`REBP_CMP_F] ==
    cif.brk_addr[`REBP_CMP_F]);
  assign cif.hit = hit_r;

  // One registered event; a held match cannot pulse twice in a row
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      hit_r <= 1'b0;
    end else if (clk_en) begin
      hit_r <= match && !hit_r;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_hit_cause;
    @(posedge clock) disable iff (!rst_b)
    hit_r |-> $past(cif.bus_fetch) && $past(cif.brk_en) &&
      $past(cif.bus_valid) && $past(cif.armed) &&
      ($past(cif.bus_addr[`REBP_CMP_F]) == $past(cif.brk_addr[`REBP_CMP_F]));
  endproperty
  a_hit_cause: assert property (p_hit_cause)
    else $error("break without enabled matching fetch");

  property p_hit_single;
    @(posedge clock) disable iff (!rst_b)
    clk_en && hit_r |=> !hit_r;
  endproperty
  a_hit_single: assert property (p_hit_single)
    else $error("break event longer than one cycle");

  property p_hit_a0;
    @(posedge clock) disable iff (!rst_b)
    clk_en && cif.bus_valid && cif.bus_fetch && cif.armed && cif.brk_en &&
      (cif.bus_addr[`REBP_CMP_F] == cif.brk_addr[`REBP_CMP_F]) && !hit_r
      |=> hit_r;
  endproperty
  a_hit_a0: assert property (p_hit_a0)
    else $error("match differing only in bit zero gave no break");
endmodule

/* design/rebp_top.sv */
// Run entry decode, pod function registers and break control
`include "rebp_defs.svh"
module rebp_top (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clk_en,
  // Host pod function access
  input wire rebp_pkg::rebp_faddr_t host_addr,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire rebp_pkg::rebp_word_t host_wdata,
  output rebp_pkg::rebp_word_t host_rdata,
  output logic host_rvalid,
  // Run control
  input wire logic run_req,
  input wire rebp_pkg::rebp_faddr_t run_addr,
  input wire logic run_abort,
  output logic target_run_mode,
  output logic run_reject,
  output logic break_hit,
  // Processor entry state
  output rebp_pkg::rebp_word_t entry_cs,
  output rebp_pkg::rebp_word_t entry_ds,
  output rebp_pkg::rebp_word_t entry_ss,
  output rebp_pkg::rebp_word_t entry_es,
  output rebp_pkg::rebp_word_t instruction_offset,
  output rebp_pkg::rebp_phys_t entry_phys,
  // Observed target bus
  input wire rebp_pkg::rebp_phys_t bus_addr,
  input wire logic bus_fetch,
  input wire logic bus_valid,
  input wire logic byte_high_enable_n,
  // Standby reads
  input wire logic standby_read_dis,
  output logic standby_read_active
);
  import rebp_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  rebp_state_t state_r;
  rebp_state_t state_nxt;
  rebp_form_t form;
  logic brk_en_r;
  rebp_word_t brk_lo_r;
  logic [7:0] brk_hi_r;
  rebp_word_t brk_stat_r;
  rebp_word_t cs_ini_r;
  rebp_word_t ds_ini_r;
  rebp_word_t ss_ini_r;
  rebp_word_t es_ini_r;
  rebp_word_t host_rdata_r;
  logic host_rvalid_r;
  logic run_reject_r;
  rebp_word_t ent_cs_r;
  rebp_word_t ent_ds_r;
  rebp_word_t ent_ss_r;
  rebp_word_t ent_es_r;
  rebp_word_t ent_ip_r;
  rebp_phys_t ent_phys_r;
  logic is_def;
  logic is_top;
  logic is_real;
  logic is_seg;
  logic form_ok;
  logic idle;
  logic running;
  logic start;
  logic reject;
  logic stop_brk;
  logic wr_brk_en;
  logic wr_brk_lo;
  logic wr_brk_hi;
  logic wr_cs;
  logic wr_ds;
  logic wr_ss;
  logic wr_es;
  rebp_word_t rd_val;
  rebp_word_t nx_cs;
  rebp_word_t nx_ds;
  rebp_word_t nx_ss;
  rebp_word_t nx_es;
  rebp_word_t nx_ip;
  logic [19:0] nx_lin;
  rebp_phys_t nx_phys;

  rebp_cmp_if cif ();

  // Real-mode physical address: segment times sixteen plus offset
  function automatic logic [19:0] seg_phys(rebp_word_t seg, rebp_word_t off);
    seg_phys = {seg, `REBP_NIB0} + {`REBP_NIB0, off};
  endfunction

  // ----------------------------------------------------------------
  // Entry address decode
  // ----------------------------------------------------------------
  // Default wins over the top form it falls inside of
  assign is_def = run_addr == `REBP_DEFAULT_ENTRY;
  // Odd last byte of the top and real windows is refused
  assign is_top = (run_addr[`REBP_PREFIX_F] == `REBP_TOP_PREFIX) &&
    (run_addr[`REBP_OFFS_F] != `REBP_TOP_END);
  assign is_real = (run_addr[`REBP_REAL_PFX_F] == `REBP_REAL_PREFIX) &&
    (run_addr[`REBP_LOW20_F] != `REBP_REAL_END);
  assign is_seg = run_addr[`REBP_PREFIX_F] == `REBP_SEG_PREFIX;
  assign form = is_def ? REBP_FORM_DEF :
    is_top ? REBP_FORM_TOP :
    is_real ? REBP_FORM_REAL :
    is_seg ? REBP_FORM_SEG : REBP_FORM_BAD;
  assign form_ok = form != REBP_FORM_BAD;

  // Entry segment values per form
  assign nx_cs = (is_def || is_top) ? `REBP_CS_RST :
    is_real ? {run_addr[`REBP_Y_F], `REBP_SEG_PAD} :
    cs_ini_r;
  assign nx_ds = is_seg ? ds_ini_r : `REBP_ZERO16;
  assign nx_ss = is_seg ? ss_ini_r : `REBP_ZERO16;
  assign nx_es = is_seg ? es_ini_r : `REBP_ZERO16;
  assign nx_ip = is_def ? `REBP_IP_RST : run_addr[`REBP_OFFS_F];
  assign nx_lin = seg_phys(nx_cs, nx_ip);
  // Top window forces the upper nibble; others stay under 1M
  assign nx_phys = (is_def || is_top) ? {`REBP_TOP_NIB, nx_lin} :
    {`REBP_NIB0, nx_lin};

  // ----------------------------------------------------------------
  // Run state machine
  // ----------------------------------------------------------------
  assign idle = state_r == REBP_IDLE;
  assign running = state_r == REBP_RUN;
  assign start = idle && run_req && form_ok;
  assign reject = idle && run_req && !form_ok;
  assign stop_brk = running && cif.hit;

  // Next state; a stuck code falls back to idle
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      REBP_IDLE: begin
        if (start) begin
          state_nxt = REBP_RUN;
        end
      end
      REBP_RUN: begin
        if (cif.hit || run_abort) begin
          state_nxt = REBP_IDLE;
        end
      end
      default: begin
        state_nxt = REBP_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= REBP_IDLE;
    end else if (clk_en) begin
      state_r <= state_nxt;
    end
  end

  // Entry state captured at the start of a run
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ent_cs_r <= `REBP_CS_RST;
      ent_ds_r <= `REBP_ZERO16;
      ent_ss_r <= `REBP_ZERO16;
      ent_es_r <= `REBP_ZERO16;
      ent_ip_r <= `REBP_IP_RST;
      ent_phys_r <= `REBP_PHYS_RST;
    end else if (clk_en && start) begin
      ent_cs_r <= nx_cs;
      ent_ds_r <= nx_ds;
      ent_ss_r <= nx_ss;
      ent_es_r <= nx_es;
      ent_ip_r <= nx_ip;
      ent_phys_r <= nx_phys;
    end
  end

  // Refusal pulse and break status; entry and break never coincide
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      run_reject_r <= 1'b0;
      brk_stat_r <= `REBP_ZERO16;
    end else if (clk_en) begin
      run_reject_r <= reject;
      if (start) begin
        brk_stat_r <= `REBP_ZERO16;
      end else if (stop_brk) begin
        brk_stat_r <= `REBP_BRK_FLAG;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pod function registers
  // ----------------------------------------------------------------
  assign wr_brk_en = host_wr && (host_addr == `REBP_OFS_BRK_EN);
  assign wr_brk_lo = host_wr && (host_addr == `REBP_OFS_BRK_LO);
  assign wr_brk_hi = host_wr && (host_addr == `REBP_OFS_BRK_HI);
  assign wr_cs = host_wr && (host_addr == `REBP_OFS_CS_INI);
  assign wr_ds = host_wr && (host_addr == `REBP_OFS_DS_INI);
  assign wr_ss = host_wr && (host_addr == `REBP_OFS_SS_INI);
  assign wr_es = host_wr && (host_addr == `REBP_OFS_ES_INI);

  // Break setup; address survives enable being cleared
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      brk_en_r <= 1'b0;
      brk_lo_r <= `REBP_ZERO16;
      brk_hi_r <= `REBP_ZERO8;
    end else if (clk_en) begin
      if (wr_brk_en) begin
        brk_en_r <= host_wdata[`REBP_EN_BIT];
      end
      if (wr_brk_lo) begin
        brk_lo_r <= host_wdata;
      end
      if (wr_brk_hi) begin
        brk_hi_r <= host_wdata[`REBP_BYTE_LO_F];
      end
    end
  end

  // Segment initial values; only host writes touch them, never a run
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cs_ini_r <= `REBP_CS_RST;
      ds_ini_r <= `REBP_ZERO16;
      ss_ini_r <= `REBP_ZERO16;
      es_ini_r <= `REBP_ZERO16;
    end else if (clk_en) begin
      if (wr_cs) begin
        cs_ini_r <= host_wdata;
      end
      if (wr_ds) begin
        ds_ini_r <= host_wdata;
      end
      if (wr_ss) begin
        ss_ini_r <= host_wdata;
      end
      if (wr_es) begin
        es_ini_r <= host_wdata;
      end
    end
  end

  // Read mux; unmapped addresses read zero
  assign rd_val =
    (host_addr == `REBP_OFS_BRK_EN) ? {`REBP_ZERO15, brk_en_r} :
    (host_addr == `REBP_OFS_BRK_LO) ? brk_lo_r :
    (host_addr == `REBP_OFS_BRK_HI) ? {`REBP_ZERO8, brk_hi_r} :
    (host_addr == `REBP_OFS_BRK_ST) ? brk_stat_r :
    (host_addr == `REBP_OFS_CS_INI) ? cs_ini_r :
    (host_addr == `REBP_OFS_DS_INI) ? ds_ini_r :
    (host_addr == `REBP_OFS_SS_INI) ? ss_ini_r :
    (host_addr == `REBP_OFS_ES_INI) ? es_ini_r : `REBP_ZERO16;

  // Read data is registered; it holds until the next read
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      host_rdata_r <= `REBP_ZERO16;
      host_rvalid_r <= 1'b0;
    end else if (clk_en) begin
      host_rvalid_r <= host_rd;
      if (host_rd) begin
        host_rdata_r <= rd_val;
      end
    end
  end

  // ----------------------------------------------------------------
  // Comparator and outputs
  // ----------------------------------------------------------------
  // Upper byte lane enable adds nothing: bit zero is not compared
  assign cif.brk_en = brk_en_r;
  assign cif.brk_addr = {brk_hi_r, brk_lo_r};
  assign cif.armed = running;
  assign cif.bus_addr = bus_addr;
  assign cif.bus_fetch = bus_fetch;
  assign cif.bus_valid = bus_valid;

  rebp_cmp u_cmp (
    .clock(clock),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .cif(cif)
  );

  assign host_rdata = host_rdata_r;
  assign host_rvalid = host_rvalid_r;
  assign target_run_mode = running;
  assign run_reject = run_reject_r;
  assign break_hit = stop_brk;
  assign entry_cs = ent_cs_r;
  assign entry_ds = ent_ds_r;
  assign entry_ss = ent_ss_r;
  assign entry_es = ent_es_r;
  assign instruction_offset = ent_ip_r;
  assign entry_phys = ent_phys_r;
  // Standby reads come back once the run has ended
  assign standby_read_active = idle && !standby_read_dis;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  sequence s_take;
    clk_en && idle && run_req && form_ok;
  endsequence
  sequence s_break;
    clk_en && running && cif.hit;
  endsequence

  property p_entry_def;
    s_take ##0 is_def |=> entry_cs == `REBP_CS_RST &&
      instruction_offset == `REBP_IP_RST && entry_ds == `REBP_ZERO16 &&
      entry_ss == `REBP_ZERO16 && entry_es == `REBP_ZERO16;
  endproperty
  a_entry_def: assert property (p_entry_def)
    else $error("default entry state wrong");

  property p_entry_top;
    s_take ##0 (is_top && !is_def) |=> entry_cs == `REBP_CS_RST &&
      entry_phys[`REBP_UPPER_F] == `REBP_TOP_NIB &&
      instruction_offset == $past(run_addr[`REBP_OFFS_F]);
  endproperty
  a_entry_top: assert property (p_entry_top)
    else $error("top window entry state wrong");

  property p_entry_real;
    s_take ##0 is_real |=>
      entry_cs == {$past(run_addr[`REBP_Y_F]), `REBP_SEG_PAD} &&
      entry_phys == {`REBP_NIB0, $past(run_addr[`REBP_LOW20_F])};
  endproperty
  a_entry_real: assert property (p_entry_real)
    else $error("real mode entry state wrong");

  property p_entry_seg;
    s_take ##0 is_seg |=> entry_cs == $past(cs_ini_r) &&
      entry_es == $past(es_ini_r) &&
      entry_phys == {`REBP_NIB0, seg_phys(entry_cs, instruction_offset)};
  endproperty
  a_entry_seg: assert property (p_entry_seg)
    else $error("stored segment entry state wrong");

  property p_reject;
    clk_en && idle && run_req && !form_ok |=> run_reject && !target_run_mode;
  endproperty
  a_reject: assert property (p_reject)
    else $error("bad entry address started a run");

  property p_stat_clear;
    s_take |=> target_run_mode && brk_stat_r == `REBP_ZERO16;
  endproperty
  a_stat_clear: assert property (p_stat_clear)
    else $error("break status not cleared on run entry");

  property p_break_stop;
    s_break |=> brk_stat_r == `REBP_BRK_FLAG && !target_run_mode;
  endproperty
  a_break_stop: assert property (p_break_stop)
    else $error("break did not end the run");

  property p_en_bit;
    clk_en && wr_brk_en |=> brk_en_r == $past(host_wdata[`REBP_EN_BIT]);
  endproperty
  a_en_bit: assert property (p_en_bit)
    else $error("break enable bit not written");

  property p_hi_zero;
    clk_en && host_rd && host_addr == `REBP_OFS_BRK_HI |=>
      host_rvalid && host_rdata[`REBP_BYTE_HI_F] == `REBP_ZERO8;
  endproperty
  a_hi_zero: assert property (p_hi_zero)
    else $error("break address high byte not zero");

  property p_seg_hold;
    running && !wr_cs |=> cs_ini_r == $past(cs_ini_r);
  endproperty
  a_seg_hold: assert property (p_seg_hold)
    else $error("stored code segment changed during run");
endmodule

/* pkg/rebp_cmp_if.sv */
// Link between the run control and the break comparator
interface rebp_cmp_if;
  logic brk_en;
  rebp_pkg::rebp_phys_t brk_addr;
  logic armed;
  rebp_pkg::rebp_phys_t bus_addr;
  logic bus_fetch;
  logic bus_valid;
  logic hit;
  modport ctl (
    output brk_en, brk_addr, armed, bus_addr, bus_fetch, bus_valid,
    input hit
  );
  modport cmp (
    input brk_en, brk_addr, armed, bus_addr, bus_fetch, bus_valid,
    output hit
  );
endinterface

/* pkg/rebp_defs.svh */
// Constants for the run entry and breakpoint block
`ifndef REBP_DEFS_SVH
`define REBP_DEFS_SVH
// Pod function addresses
`define REBP_OFS_BRK_EN 32'hF00000B0
`define REBP_OFS_BRK_LO 32'hF00000B2
`define REBP_OFS_BRK_HI 32'hF00000B4
`define REBP_OFS_BRK_ST 32'hF00000B6
`define REBP_OFS_CS_INI 32'hF0000130
`define REBP_OFS_DS_INI 32'hF0000132
`define REBP_OFS_SS_INI 32'hF0000134
`define REBP_OFS_ES_INI 32'hF0000136
// Reset and flag values
`define REBP_CS_RST 16'hF000
`define REBP_IP_RST 16'hFFF0
`define REBP_PHYS_RST 24'hFFFFF0
`define REBP_ZERO16 16'h0000
`define REBP_ZERO8 8'h00
`define REBP_ZERO15 15'h0000
`define REBP_BRK_FLAG 16'hBBBB
// Entry address forms
`define REBP_DEFAULT_ENTRY 32'h00FFFFF0
`define REBP_TOP_PREFIX 16'h00FF
`define REBP_SEG_PREFIX 16'hF000
`define REBP_REAL_PREFIX 12'h000
`define REBP_TOP_END 16'hFFFF
`define REBP_REAL_END 20'hFFFFF
`define REBP_SEG_PAD 12'h000
`define REBP_TOP_NIB 4'hF
`define REBP_NIB0 4'h0
// Field positions
`define REBP_PREFIX_F 31:16
`define REBP_REAL_PFX_F 31:20
`define REBP_OFFS_F 15:0
`define REBP_LOW20_F 19:0
`define REBP_Y_F 19:16
`define REBP_UPPER_F 23:20
`define REBP_BYTE_HI_F 15:8
`define REBP_BYTE_LO_F 7:0
`define REBP_CMP_F 23:1
`define REBP_EN_BIT 0
`endif

/* pkg/rebp_pkg.sv */
// Types shared by the run entry and breakpoint block
package rebp_pkg;
  typedef logic [15:0] rebp_word_t;
  typedef logic [23:0] rebp_phys_t;
  typedef logic [31:0] rebp_faddr_t;
  typedef enum logic [1:0] {
    REBP_IDLE = 2'b01,
    REBP_RUN = 2'b10
  } rebp_state_t;
  typedef enum logic [3:0] {
    REBP_FORM_BAD = 4'b0000,
    REBP_FORM_DEF = 4'b0001,
    REBP_FORM_TOP = 4'b0010,
    REBP_FORM_REAL = 4'b0100,
    REBP_FORM_SEG = 4'b1000
  } rebp_form_t;
endpackage

/* tb/rebp_bus_model.sv */
// Target bus partner model: one observed bus cycle per bench request
module rebp_bus_model (
  // Clock
  input wire logic clock,
  // Request from the bench
  input wire logic go,
  input wire rebp_pkg::rebp_phys_t a,
  input wire logic f,
  // Observed target bus
  output rebp_pkg::rebp_phys_t bus_addr,
  output logic bus_fetch,
  output logic bus_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Bus cycle
  // ----------------------------------------
  initial begin
    bus_valid = 1'b0;
    bus_addr = 24'h000000;
    bus_fetch = 1'b0;
  end
  // Idle lines flip so a stale address never matches by luck
  always @(posedge clock) begin
    bus_valid <= go;
    bus_addr <= go ? a : ~bus_addr;
    bus_fetch <= go ? f : ~bus_fetch;
  end
endmodule

/* tb/rebp_top_tb.sv */
// Self-checking bench for the run entry and breakpoint block
`include "rebp_defs.svh"
module rebp_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import rebp_pkg::*;
  logic clock, rst_b, host_wr, host_rd, run_req, run_abort, go, f, clk_en;
  logic host_rvalid, target_run_mode, run_reject, break_hit;
  logic bus_fetch, bus_valid, standby_read_dis, standby_read_active;
  rebp_faddr_t host_addr, run_addr;
  rebp_word_t host_wdata, host_rdata, entry_cs, entry_ds, entry_ss;
  rebp_word_t entry_es, instruction_offset;
  rebp_word_t ini [4];
  rebp_phys_t entry_phys, bus_addr, a, bk;
  logic [31:0] seed = 32'h00006BAD;
  logic [31:0] r;
  int fail_count = 0;
  int n_checks = 0;
  int k;

  rebp_top target_board (.clock(clock), .rst_b(rst_b), .clk_en(clk_en),
    .host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd),
    .host_wdata(host_wdata), .host_rdata(host_rdata),
    .host_rvalid(host_rvalid), .run_req(run_req), .run_addr(run_addr),
    .run_abort(run_abort), .target_run_mode(target_run_mode),
    .run_reject(run_reject), .break_hit(break_hit), .entry_cs(entry_cs),
    .entry_ds(entry_ds), .entry_ss(entry_ss), .entry_es(entry_es),
    .instruction_offset(instruction_offset), .entry_phys(entry_phys),
    .bus_addr(bus_addr), .bus_fetch(bus_fetch), .bus_valid(bus_valid),
    .byte_high_enable_n(1'b0), .standby_read_dis(standby_read_dis),
    .standby_read_active(standby_read_active));
  rebp_bus_model bus (.clock(clock), .go(go), .a(a), .f(f),
    .bus_addr(bus_addr), .bus_fetch(bus_fetch), .bus_valid(bus_valid));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Seed 27565, xorshift keeps the run repeatable
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(string n, logic [23:0] e, logic [23:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Host write: one-cycle strobe, gap cycle before the next
  task automatic wr(rebp_faddr_t ad, rebp_word_t d);
    @(posedge clock);
    host_wr <= 1'b1;
    host_addr <= ad;
    host_wdata <= d;
    @(posedge clock);
    host_wr <= 1'b0;
  endtask
  task automatic rd(rebp_faddr_t ad, rebp_word_t e);
    @(posedge clock);
    host_rd <= 1'b1;
    host_addr <= ad;
    @(posedge clock);
    host_rd <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      @(negedge clock);
      if (host_rvalid === 1'b1) begin
        chk("host_rdata", e, host_rdata);
        return;
      end
    end
    fail_count++;
    $display("FAIL host_rvalid expected 1 seen 0");
    end_of_test();
  endtask
  // Reference entry decode, then request a run
  task automatic run(rebp_faddr_t ad);
    logic ok, cd;
    rebp_word_t cs;
    rebp_word_t d [3];
    rebp_phys_t ph;
    ok = 1'b1;
    cd = (ad == `REBP_DEFAULT_ENTRY);
    cs = 16'hF000;
    d = '{16'h0000, 16'h0000, 16'h0000};
    ph = {8'hFF, ad[15:0]};
    if (ad[31:16] == 16'h00FF) begin
      ok = (ad[15:0] != 16'hFFFF);
    end else if (ad[31:20] == 12'h000) begin
      ok = (ad[19:0] != 20'hFFFFF);
      cd = 1'b1;
      cs = {ad[19:16], 12'h000};
      ph = {4'h0, ad[19:0]};
    end else if (ad[31:16] == 16'hF000) begin
      cd = 1'b1;
      cs = ini[0];
      d = '{ini[1], ini[2], ini[3]};
      ph = {4'h0, {cs, 4'h0} + {4'h0, ad[15:0]}};
    end else begin
      ok = 1'b0;
    end
    @(posedge clock);
    run_req <= 1'b1;
    run_addr <= ad;
    @(posedge clock);
    run_req <= 1'b0;
    @(negedge clock);
    chk("target_run_mode", ok, target_run_mode);
    chk("run_reject", !ok, run_reject);
    if (ok) begin
      chk("entry_cs", cs, entry_cs);
      chk("instruction_offset", ad[15:0], instruction_offset);
      chk("entry_phys", ph, entry_phys);
      if (cd) begin
        chk("entry_ds", d[0], entry_ds);
        chk("entry_ss", d[1], entry_ss);
        chk("entry_es", d[2], entry_es);
      end
    end
  endtask
  task automatic stop();
    @(posedge clock);
    run_abort <= 1'b1;
    @(posedge clock);
    run_abort <= 1'b0;
  endtask
  // One observed bus cycle; a hit must be a single pulse
  task automatic fetch(rebp_phys_t ad, logic fe, logic e);
    int h;
    h = 0;
    @(posedge clock);
    go <= 1'b1;
    a <= ad;
    f <= fe;
    @(posedge clock);
    go <= 1'b0;
    repeat (6) begin
      @(negedge clock);
      h += (break_hit === 1'b1);
    end
    chk("break_hit", e, h == 1);
    chk("target_run_mode", !e, target_run_mode);
  endtask

  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial begin
    {rst_b, host_wr, host_rd, run_req, run_abort, go, f} = '0;
    {host_addr, host_wdata, run_addr, a, standby_read_dis} = '0;
    clk_en = 1'b1;
    repeat (10) @(posedge clock);
    rst_b <= 1'b1;
    rd(`REBP_OFS_CS_INI, 16'hF000);
    rd(`REBP_OFS_ES_INI, 16'h0000);
    rd(`REBP_OFS_BRK_EN, 16'h0000);
    rd(32'hF00000C0, 16'h0000);
    wr(`REBP_OFS_BRK_EN, 16'hFFFE);
    rd(`REBP_OFS_BRK_EN, 16'h0000);
    wr(`REBP_OFS_BRK_EN, 16'hFFFF);
    rd(`REBP_OFS_BRK_EN, 16'h0001);
    r = rnd();
    bk = r[23:0];
    wr(`REBP_OFS_BRK_LO, bk[15:0]);
    wr(`REBP_OFS_BRK_HI, {8'hA5, bk[23:16]});
    rd(`REBP_OFS_BRK_HI, {8'h00, bk[23:16]});
    rd(`REBP_OFS_BRK_LO, bk[15:0]);
    // A frozen clock enable must swallow a write
    @(posedge clock);
    clk_en <= 1'b0;
    wr(`REBP_OFS_BRK_LO, ~bk[15:0]);
    clk_en <= 1'b1;
    rd(`REBP_OFS_BRK_LO, bk[15:0]);
    for (k = 0; k < 4; k++) begin
      r = rnd();
      ini[k] = r[15:0];
      wr(`REBP_OFS_CS_INI + 2 * k, ini[k]);
    end
    for (k = 0; k < 4; k++) begin
      rd(`REBP_OFS_CS_INI + 2 * k, ini[k]);
    end
    // Host stand-in offers only legal or deliberately refused forms
    run(`REBP_DEFAULT_ENTRY);
    stop();
    run(32'h00FF1234);
    stop();
    run(32'h00FFFFFF);
    run(32'h000FFFFF);
    run(32'h12345678);
    r = rnd();
    run({12'h000, r[19:1], 1'b0});
    stop();
    run({16'hF000, r[31:16]});
    rd(`REBP_OFS_BRK_ST, 16'h0000);
    fetch(bk, 1'b0, 1'b0);
    fetch(bk ^ 24'h000001, 1'b1, 1'b1);
    rd(`REBP_OFS_BRK_ST, 16'hBBBB);
    chk("standby_read_active", 1'b1, standby_read_active);
    @(posedge clock);
    standby_read_dis <= 1'b1;
    @(negedge clock);
    chk("standby_read_active", 1'b0, standby_read_active);
    for (k = 0; k < 4; k++) begin
      rd(`REBP_OFS_CS_INI + 2 * k, ini[k]);
    end
    // Disabled breaks must not fire, address must survive
    wr(`REBP_OFS_BRK_EN, 16'h0000);
    run(`REBP_DEFAULT_ENTRY);
    fetch(bk, 1'b1, 1'b0);
    wr(`REBP_OFS_BRK_EN, 16'h0001);
    fetch(bk, 1'b1, 1'b1);
    end_of_test();
  end
endmodule
